// *** verif/at_bus_cycle_sequencer_test.sv ***
`timescale 1ns/100ps
`include "bus_seq_map.vh"
module at_bus_cycle_sequencer_test;
  reg clk, nrst, bsc, async_mode, start, local_hit, cw, chb, ref_on;
  reg dma, dwr, dcopy, wide, is_io, ab, dn, pa, pc;
  reg [1:0] ty;
  reg iack;
  reg [3:0] stb;
  reg [3:0] dly, wst;
  reg [7:0] stall;
  reg [1:0] cds [0:3];
  wire ale, mr_n, mw_n, ir_n, iw_n, ab_o, cb0, cb1, en_n, done_n, busy;
  wire m16_n, i16_n, rdy;
  wire cmd_on = !(mr_n & mw_n & ir_n & iw_n);
  integer err_count, samples_checked, i, k, n_ale, t0, te, t_dl, w1, gap;
  integer nb;
  at_bus_cycle_sequencer u_at_bus_cycle_sequencer
  (
    .clk(clk), .nrst(nrst), .bus_state_clk(bsc), .async_mode(async_mode),
    .cycle_start(start), .local_mem_hit(local_hit), .cpu_cycle_type(ty),
    .cpu_word(cw), .cpu_high_byte(chb), .int_ack(iack),
    .refresh_active(ref_on), .dma_grant_ack(dma), .dma_write(dwr),
    .dma_lo_hi_copy(dcopy), .cmd_delay(dly), .wait_states(wst),
    .mem_cs16_n(m16_n), .io_cs16_n(i16_n), .io_chrdy(rdy), .ale(ale),
    .buffered_mem_read_n(mr_n), .buffered_mem_write_n(mw_n),
    .buffered_io_read_n(ir_n), .buffered_io_write_n(iw_n),
    .expansion_byte_addr_bit(ab_o), .conv_code_bit0(cb0),
    .conv_code_bit1(cb1), .conv_code_enable_n(en_n),
    .cycle_done_n(done_n), .busy(busy)
  );
  bus_target_model u_bus_target_model
  (
    .clk(clk), .ale(ale), .busy(busy), .cmd_on(cmd_on), .is_io(is_io),
    .wide(wide), .stall(stall), .mem_cs16_n(m16_n), .io_cs16_n(i16_n),
    .io_chrdy(rdy)
  );
  // 25 MHz clock; bus state clock free running at 320 ns, offset phase
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    bsc = 1'b0;
    #7;
    forever #160 bsc = ~bsc;
  end
  // Hang guard, well past the twelve hundred or so clocks the run needs
  initial
  begin
    repeat (60000) @(posedge clk);
    err_count = err_count + 1;
    tally_and_finish;
  end
  task chk(input [63:0] nm, input [31:0] e, input [31:0] s);
  begin
    samples_checked = samples_checked + 1;
    if (s !== e)
    begin
      err_count = err_count + 1;
      $display("FAIL %0s exp %0h got %0h", nm, e, s);
    end
  end
  endtask
  // Issue one cycle, log the pins in clocks until done
  task run;
  begin
    @(negedge clk);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    {n_ale, nb, w1, gap, t_dl, t0, te} = 224'h0;
    {dn, pa, pc} = 3'h0;
    for (k = 0; k < 2000 && !dn; k = k + 1)
    begin
      @(negedge clk);
      if (ale && !pa) n_ale = n_ale + 1;
      if (!ale && pa) t0 = k;
      if (cmd_on && !pc)
      begin
        nb = nb + 1;
        t_dl = (nb == 1) ? k - t0 : t_dl;
        gap = k - te;
        cds[nb & 3] = {cb1, cb0};
        ab = ab_o;
        stb = {mr_n, mw_n, ir_n, iw_n};
      end
      if (cmd_on && nb == 1) w1 = w1 + 1;
      if (!cmd_on && pc) te = k;
      dn = (done_n === 1'b0);
      {pa, pc} = {ale, cmd_on};
    end
    chk("done", 1, dn);
    repeat (20) @(negedge clk);
  end
  endtask
  task t_basic;
  begin
    {ty, cw, chb, wide, is_io, dly, wst, stall} =
      {`CYC_MEM_RD, 4'ha, 4'h1, 4'h0, 8'h00};
    run;
    chk("ale", 1, n_ale);
    chk("delay", 8, t_dl);
    chk("width", 16, w1);
    chk("bytes", 1, nb);
    chk("code", `CODE_LOW_RD, cds[1]);
  end
  endtask
  // Byte cycles of all four kinds, both bytes, no delay
  task t_codes;
  begin
    for (i = 0; i < 8; i = i + 1)
    begin
      {ty, cw, chb, wide, is_io, dly, wst} =
        {i[2], !i[0], 1'b0, i[1], 1'b1, i[2], 8'h00};
      run;
      chk("bcode", {i[1], i[0]}, cds[1]);
      chk("abit", i[1], ab);
      chk("nodly", 0, t_dl);
      chk("strobe", 4'hf ^ (4'h8 >> ty), stb);
    end
  end
  endtask
  // Word write then word read to an 8-bit target
  task t_split;
  begin
    for (i = 0; i < 2; i = i + 1)
    begin
      {ty, cw, chb, wide, is_io, dly, wst} = {1'b0, !i[0], 4'h8, 8'h00};
      run;
      chk("split", 2, nb);
      chk("one_ale", 1, n_ale);
      chk("recov", 16, gap);
      chk("lo", {1'b0, i[0]}, cds[1]);
      chk("hi", {1'b1, i[0]}, cds[2]);
      chk("hi_bit", 1, ab);
    end
  end
  endtask
  // Two programmed waits, then one wait plus a stalled ready
  task t_retry;
  begin
    {ty, cw, chb, wide, is_io, dly, wst, stall} =
      {`CYC_IO_RD, 4'hb, 8'h02, 8'h00};
    run;
    chk("waits", 48, w1);
    {wst, stall} = {4'h1, 8'h20};
    run;
    chk("retry", 48, w1);
    stall = 8'h00;
  end
  endtask
  task t_local;
  begin
    local_hit = 1'b1;
    start = 1'b1;
    n_ale = 0;
    for (k = 0; k < 40; k = k + 1)
    begin
      @(negedge clk);
      if (ale !== 1'b0 || busy !== 1'b0) n_ale = n_ale + 1;
    end
    {start, local_hit} = 2'h0;
    chk("local", 0, n_ale);
  end
  endtask
  // Float, copy high to low, copy low to high
  task t_dma;
  begin
    dma = 1'b1;
    for (i = 0; i < 3; i = i + 1)
    begin
      {dcopy, dwr} = {i != 0, i == 2};
      repeat (4) @(negedge clk);
      chk("dma_en", 0, en_n);
      chk("dma_code", {i != 0, i == 1}, {cb1, cb0});
    end
    dma = 1'b0;
    repeat (4) @(negedge clk);
    chk("idle_en", 1, en_n);
  end
  endtask
  task t_refresh;
  begin
    ref_on = 1'b1;
    repeat (20) @(negedge clk);
    chk("ref_en", 1, en_n);
    ref_on = 1'b0;
    repeat (20) @(negedge clk);
  end
  endtask
  task t_async;
  begin
    async_mode = 1'b1;
    {ty, cw, chb, wide, is_io, dly, wst, stall} =
      {`CYC_MEM_WR, 4'ha, 4'h2, 4'h0, 8'h00};
    run;
    chk("as_delay", 16, t_dl);
    chk("as_code", `CODE_LOW_WR, cds[1]);
    async_mode = 1'b0;
  end
  endtask
  // Interrupt acknowledge: no io read strobe, cycle still ends
  task t_iack;
  begin
    iack = 1'b1;
    {ty, cw, chb, wide, is_io, dly, wst, stall} =
      {`CYC_IO_RD, 4'hb, 8'h00, 8'h00};
    run;
    chk("iack_rd", 0, nb);
    iack = 1'b0;
  end
  endtask
  task tally_and_finish;
  begin
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  initial
  begin
    err_count = 0;
    samples_checked = 0;
    {nrst, async_mode, start, local_hit, cw, chb, ref_on} = 7'h00;
    iack = 1'b0;
    {dma, dwr, dcopy, wide, is_io, ty, dly, wst, stall} = 23'h0;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    t_basic;
    t_codes;
    t_split;
    t_retry;
    t_local;
    t_dma;
    t_refresh;
    t_async;
    t_iack;
    tally_and_finish;
  end
endmodule

// *** verif/bus_seq_sva.sv ***
`timescale 1ns/100ps
// ------------------------------
// Sequencer pin checker
// ------------------------------
module bus_seq_sva
(
  input wire clk,
  input wire nrst,
  input wire ale,
  input wire busy,
  input wire cycle_done_n,
  input wire conv_code_bit0,
  input wire conv_code_bit1,
  input wire conv_code_enable_n,
  input wire buffered_mem_read_n,
  input wire buffered_mem_write_n,
  input wire buffered_io_read_n,
  input wire buffered_io_write_n,
  input wire refresh_active,
  input wire dma_grant_ack
);
  // Any command strobe active
  wire cmd_on = !(buffered_mem_read_n & buffered_mem_write_n &
    buffered_io_read_n & buffered_io_write_n);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // One bus state is eight clocks at the rates used here
  sequence s_ale;
    ale[*8] ##1 !ale;
  endsequence
  sequence s_done;
    !cmd_on ##1 cycle_done_n;
  endsequence
  AST_ALE_ONE: assert property ($rose(ale) |-> s_ale)
    else $error("ale width wrong");
  AST_CMD_LATE: assert property
    ($rose(cmd_on) && !refresh_active |-> !ale && busy)
    else $error("command overlaps ale");
  AST_CMD_MIN: assert property ($rose(cmd_on) |-> ##15 cmd_on)
    else $error("command too short");
  AST_DONE: assert property ($fell(cycle_done_n) |-> s_done)
    else $error("done pulse wrong");
  AST_CODE: assert property
    (cmd_on && $past(cmd_on) |-> $stable({conv_code_bit1, conv_code_bit0}))
    else $error("code moved in command");
  AST_EN_CMD: assert property
    (cmd_on && !refresh_active && !$past(refresh_active) |->
     !conv_code_enable_n)
    else $error("enable high in command");
  AST_EN_REF: assert property
    (refresh_active[*2] |-> conv_code_enable_n)
    else $error("enable low in refresh");
  AST_EN_DMA: assert property
    (dma_grant_ack[*2] |-> !conv_code_enable_n)
    else $error("enable high in dma");
endmodule
bind at_bus_cycle_sequencer bus_seq_sva u_bus_seq_sva (.clk, .nrst, .ale,
  .busy, .cycle_done_n, .conv_code_bit0, .conv_code_bit1,
  .conv_code_enable_n, .buffered_mem_read_n, .buffered_mem_write_n,
  .buffered_io_read_n, .buffered_io_write_n, .refresh_active,
  .dma_grant_ack);

// *** verif/bus_target_model.sv ***
`timescale 1ns/100ps
// Expansion target: sizing and ready lines, all pulled up when idle
module bus_target_model
(
  input wire clk,
  input wire ale,
  input wire busy,
  input wire cmd_on,
  input wire is_io,
  input wire wide,
  input wire [7:0] stall,
  output reg mem_cs16_n,
  output reg io_cs16_n,
  output reg io_chrdy
);
  reg sel_ff;
  reg [7:0] cnt_ff;
  initial
  begin
    {sel_ff, cnt_ff, mem_cs16_n, io_cs16_n, io_chrdy} = 12'h007;
  end
  // Select from ale to end of cycle; ready held low for stall clocks
  always @(negedge clk)
  begin
    sel_ff <= ale | (sel_ff & busy);
    cnt_ff <= cmd_on ? cnt_ff + 8'h01 : 8'h00;
    mem_cs16_n <= !(wide & !is_io & (ale | sel_ff));
    io_cs16_n <= !(wide & is_io & (ale | sel_ff));
    io_chrdy <= !(cmd_on & (cnt_ff < stall));
  end
endmodule

// *** verilog/at_bus_cycle_sequencer.v ***
`timescale 1ns/100ps
`include "bus_seq_map.vh"
// Expansion bus cycle sequencer. The bus state clock is an input from the
// clock generator; the block samples it on clk and steps once per rising
// edge, so every count below is in bus state clock periods.
//
// Cycle outline, in bus states:
//   ALE     one state, sizing pins sampled as it ends
//   DELAY   cmd_delay states, skipped when the field is zero
//   CMD     one system clock plus one per programmed wait state; ready is
//           looked at one state before the end, and a low ready buys one
//           more system clock before it is looked at again
//   RECOV   two states between the byte halves of a split transfer
//   DONE    one state, ends with the cycle-done pulse
//
// Limitation: the bus state clock is oversampled, so clk must run
// more than twice as fast as it or steps will be lost. The trade is a
// single clock domain for all state, at the cost of up to one clk of
// jitter on every bus edge.
module at_bus_cycle_sequencer
(
  input wire clk,
  input wire nrst,
  input wire bus_state_clk,
  input wire async_mode,
  input wire cycle_start,
  input wire local_mem_hit,
  input wire [1:0] cpu_cycle_type,
  input wire cpu_word,
  input wire cpu_high_byte,
  input wire int_ack,
  input wire refresh_active,
  input wire dma_grant_ack,
  input wire dma_write,
  input wire dma_lo_hi_copy,
  input wire [`FIELD_W-1:0] cmd_delay,
  input wire [`FIELD_W-1:0] wait_states,
  input wire mem_cs16_n,
  input wire io_cs16_n,
  input wire io_chrdy,
  output reg ale,
  output reg buffered_mem_read_n,
  output reg buffered_mem_write_n,
  output reg buffered_io_read_n,
  output reg buffered_io_write_n,
  output reg expansion_byte_addr_bit,
  output reg conv_code_bit0,
  output reg conv_code_bit1,
  output reg conv_code_enable_n,
  output reg cycle_done_n,
  output reg busy
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_ALE = 3'h1;
  localparam ST_DELAY = 3'h2;
  localparam ST_CMD = 3'h3;
  localparam ST_RECOV = 3'h5;
  localparam ST_DONE = 3'h6;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg [4:0] sync1_ff;
  reg [4:0] sync2_ff;
  reg bclk_prev_ff;
  wire bclk_s = sync2_ff[0];
  wire mem16_s = ~sync2_ff[1];
  wire io16_s = ~sync2_ff[2];
  wire rdy_s = sync2_ff[3];
  wire start_s = sync2_ff[4];
  wire step = bclk_s & ~bclk_prev_ff;
  // CPU request comes through two flops only in async mode
  wire start_req = async_mode ? start_s : cycle_start;

  // Pins and the bus clock are always foreign to clk
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      // Reset to idle pin levels so no false bus clock edge follows reset
      sync1_ff <= 5'h0e;
      sync2_ff <= 5'h0e;
      bclk_prev_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= {cycle_start, io_chrdy, io_cs16_n, mem_cs16_n,
                   bus_state_clk};
      sync2_ff <= sync1_ff;
      bclk_prev_ff <= bclk_s;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [3:0] cnt_ff;
  reg [3:0] nxt_cnt;
  reg [1:0] type_ff;
  reg word_ff;
  reg hi_ff;
  reg intack_ff;
  reg split_ff;
  reg nxt_split;
  reg second_ff;
  reg nxt_second;
  reg pend_ff;
  wire is_io = type_ff[1];
  wire is_rd = ~type_ff[0];
  // Wide target: memory sized at ALE fall, I/O held by target all cycle
  wire wide = is_io ? io16_s : mem16_s;

  // Next-state logic, evaluated once per bus state
  always @*
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_split = split_ff;
    nxt_second = second_ff;
    case (state_ff)
      ST_IDLE:
      begin
        nxt_second = 1'b0;
        nxt_split = 1'b0;
        if (pend_ff)
          nxt_state = ST_ALE;
      end
      ST_ALE:
      begin
        // Sample the sizing pin as ALE falls
        nxt_split = word_ff & ~wide;
        nxt_cnt = cmd_delay;
        nxt_state = (cmd_delay == 4'h0) ? ST_CMD : ST_DELAY;
        if (cmd_delay == 4'h0)
          nxt_cnt = `STATES_PER_EXPANSION_SYSTEM_CLOCK * (4'h1 + wait_states) - 4'h1;
      end
      ST_DELAY:
      begin
        nxt_cnt = cnt_ff - 4'h1;
        if (cnt_ff == 4'h1)
        begin
          nxt_state = ST_CMD;
          // One system clock plus one per wait state, in bus states
          nxt_cnt = `STATES_PER_EXPANSION_SYSTEM_CLOCK * (4'h1 + wait_states) - 4'h1;
        end
      end
      ST_CMD:
      begin
        // Programmed waits are spent when one state is left; ready is
        // looked at here, so with no waits the command is one system clock
        nxt_cnt = cnt_ff - 4'h1;
        if (cnt_ff == 4'h1 && !rdy_s)
          nxt_cnt = `STATES_PER_EXPANSION_SYSTEM_CLOCK;
        if (cnt_ff == 4'h0)
        begin
          // Ready was seen; the command ends with this system clock
          nxt_cnt = `RECOVERY_STATES - 4'h1;
          nxt_state = (split_ff & ~second_ff) ? ST_RECOV : ST_DONE;
        end
      end
      ST_RECOV:
      begin
        // Back-to-back recovery, no new ALE for the high byte
        nxt_cnt = cnt_ff - 4'h1;
        if (cnt_ff == 4'h0)
        begin
          nxt_second = 1'b1;
          nxt_state = ST_CMD;
          nxt_cnt = `STATES_PER_EXPANSION_SYSTEM_CLOCK * (4'h1 + wait_states) - 4'h1;
        end
      end
      ST_DONE:
        nxt_state = ST_IDLE;
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  // State update on bus state clock edges; request latched on clk
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      split_ff <= 1'b0;
      second_ff <= 1'b0;
      pend_ff <= 1'b0;
      type_ff <= 2'h0;
      word_ff <= 1'b0;
      hi_ff <= 1'b0;
      intack_ff <= 1'b0;
    end
    else
    begin
      // Only non-local cycles are taken over
      if (start_req & ~local_mem_hit & ~busy & ~pend_ff)
      begin
        pend_ff <= 1'b1;
        type_ff <= cpu_cycle_type;
        word_ff <= cpu_word;
        hi_ff <= cpu_high_byte;
        intack_ff <= int_ack;
      end
      else if (step & state_ff == ST_ALE)
        pend_ff <= 1'b0;
      if (step)
      begin
        // Bus state clock is twice the system clock; one step per rising edge
        state_ff <= nxt_state;
        cnt_ff <= nxt_cnt;
        split_ff <= nxt_split;
        second_ff <= nxt_second;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // Command strobes stand for the whole command state, retries included; refresh also drives memory read, int ack blocks I/O read
  wire in_cmd = (state_ff == ST_CMD);
  wire byte_hi = second_ff | (~word_ff & hi_ff);
  reg [1:0] code;

  // Conversion code choice; held fixed within each byte phase
  always @*
  begin
    if (dma_grant_ack)
      code = dma_lo_hi_copy ? (dma_write ? `CODE_DMA_LO2HI :
             `CODE_DMA_HI2LO) : `CODE_DMA_FLOAT;
    else if (byte_hi)
      code = is_rd ? `CODE_HIGH_RD : `CODE_HIGH_WR;
    else
      code = is_rd ? `CODE_LOW_RD : `CODE_LOW_WR;
  end

  // Every output is a flop; commands are active low
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ale <= 1'b0;
      buffered_mem_read_n <= 1'b1;
      buffered_mem_write_n <= 1'b1;
      buffered_io_read_n <= 1'b1;
      buffered_io_write_n <= 1'b1;
      expansion_byte_addr_bit <= 1'b0;
      conv_code_bit0 <= 1'b0;
      conv_code_bit1 <= 1'b0;
      conv_code_enable_n <= 1'b1;
      cycle_done_n <= 1'b1;
      busy <= 1'b0;
    end
    else
    begin
      ale <= (state_ff == ST_ALE);
      buffered_mem_read_n <= ~(in_cmd & ~is_io & is_rd) & ~refresh_active;
      buffered_mem_write_n <= ~(in_cmd & ~is_io & ~is_rd);
      buffered_io_read_n <= ~(in_cmd & is_io & is_rd & ~intack_ff);
      buffered_io_write_n <= ~(in_cmd & is_io & ~is_rd);
      // The byte address bit and the conversion code both move for the high byte
      expansion_byte_addr_bit <= byte_hi;
      conv_code_bit0 <= code[0];
      conv_code_bit1 <= code[1];
      if (dma_grant_ack)
        conv_code_enable_n <= 1'b0;
      else if (refresh_active)
        conv_code_enable_n <= 1'b1;
      else if (state_ff == ST_IDLE)
        conv_code_enable_n <= 1'b1;
      else if (is_rd)
        conv_code_enable_n <= ~in_cmd;
      else
        conv_code_enable_n <= 1'b0;
      // One-cycle low pulse once the last byte command has ended
      cycle_done_n <= ~(step & state_ff == ST_DONE);
      busy <= pend_ff | (state_ff != ST_IDLE);
    end
  end

endmodule

// *** verilog/bus_seq_map.vh ***
`ifndef BUS_SEQ_MAP_VH
`define BUS_SEQ_MAP_VH
// ----------------------------------------------------------------
// Cycle type encoding (cpu_cycle_type input)
// ----------------------------------------------------------------
`define CYC_MEM_RD 2'h0
`define CYC_MEM_WR 2'h1
`define CYC_IO_RD 2'h2
`define CYC_IO_WR 2'h3
// ----------------------------------------------------------------
// Conversion codes {bit1,bit0}
// ----------------------------------------------------------------
`define CODE_LOW_WR 2'h0
`define CODE_LOW_RD 2'h1
`define CODE_HIGH_WR 2'h2
`define CODE_HIGH_RD 2'h3
`define CODE_DMA_FLOAT 2'h0
`define CODE_DMA_LO2HI 2'h2
`define CODE_DMA_HI2LO 2'h3
// ----------------------------------------------------------------
// Timing counts in bus state clocks; timing field width in bits
// ----------------------------------------------------------------
`define STATES_PER_EXPANSION_SYSTEM_CLOCK 4'h2
`define RECOVERY_STATES 4'h2
`define FIELD_W 4
`endif
